// ### src/sbc_spi_pkg.sv
// Constants, types and frame layout for the SBC serial command port.
// Assumes one 25 MHz system clock; the serial link is sampled by it.
// Notes on behaviour
// - A frame is 16 input bits, opened by pulling select low.
// - Input bit is taken on every falling serial clock edge.
// - Output shifts to its next bit after every rising serial clock edge.
// - Select rising interprets the word and releases the output.
// - Bad or prohibited writes are ignored and set a sticky command fault.
// - Stop to Sleep is illegal: fault, then Restart.
// - Stop or Sleep asked from Init: fault, Normal entered instead.
// - Odd parity watchdog byte: fault, trigger or settings dropped.
// - In Stop only trigger, Normal, soft reset and status clear are valid.
// - Entering Stop with wake status pending pulses interrupt, no fault.
// - Stop to Normal with other mode bits changed: only mode changes.
// - Sleep with no wake source: fault, Restart, rest of command kept.
// - Timer-only wake source with timer off: Sleep ends at once, Restart.
// - Aux load sharing once set cannot be cleared; rest still applies.
// - Sleep with voltage measure and only wake one/two: fault, Restart.
// - Timer on-time not below its period is rejected with a fault.
// - All-zero or all-one frame means stuck input: fault.
// - Unused addresses raise the command fault only in an all-zero or all-one frame.
// - Clock count not 0 or 16: discard, error bit first in next frame.
// - Clock high at a select edge is a frame error, reported next frame.
// - Frame overlapping reset output low sets the error bit.
// - Serial output is high while reset output is low.
package sbc_spi_pkg;

    // ------------------------------------------------------------
    // Command addresses and field positions
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [6:0] ADDR_WDOG = 7'h03;
    localparam logic [6:0] ADDR_BUS_CTRL = 7'h04;
    localparam logic [6:0] ADDR_WAKE_CTRL_B = 7'h05;
    localparam logic [6:0] ADDR_TIMER = 7'h06;
    localparam logic [6:0] ADDR_DEV_STAT = 7'h43;
    localparam int STATUS_BIT = 6;
    localparam int MODE_REQ_LSB = 6;
    localparam int LS_BIT = 4;
    localparam int WAKE_ONE_BIT = 0;
    localparam int WAKE_TWO_BIT = 1;
    localparam int WAKE_TIMER_BIT = 2;
    localparam int WAKE_MEAS_BIT = 3;
    localparam int TIMER_ON_LSB = 4;
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_SLEEP = 2'h1;
    localparam logic [1:0] REQ_STOP = 2'h2;
    localparam logic [1:0] REQ_SOFT_RESET = 2'h3;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_BITS_DONE = 5'h06;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] RESTART_CYCLES = 8'h64;

    // ------------------------------------------------------------
    // Bus register map
    // ------------------------------------------------------------
    localparam logic [3:0] WB_STATUS = 4'h0;
    localparam logic [3:0] WB_CONTROL = 4'h4;
    localparam logic [3:0] WB_CONFIG = 4'h8;
    localparam logic [3:0] WB_WDOG = 4'hC;
    localparam int CTRL_CLEAR_FAULT = 0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        MODE_INIT = 5'b00001,
        MODE_NORMAL = 5'b00010,
        MODE_STOP = 5'b00100,
        MODE_SLEEP = 5'b01000,
        MODE_RESTART = 5'b10000
    } mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic write;
        logic [6:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [5:0] mode_rest;
        logic [7:0] wdog;
        logic [7:0] bus_ctrl;
        logic [7:0] wake_ctrl;
        logic [7:0] timer;
    } cfg_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// ### src/sbc_spi_checker.sv
// Serial command port of the SBC with command validation and a Wishbone view.
// Assumes the serial pins are asynchronous to clock and reset_output_n is
// driven by same-clock logic; the link clock is far slower than clock.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sbc_spi_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic select_low,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic reset_output_n,
    input wire logic wake_status_pending,
    input wire logic wake_event,
    input wire sbc_spi_pkg::wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output sbc_spi_pkg::mode_t mode,
    output sbc_spi_pkg::cfg_t cfg,
    output logic watchdog_trigger,
    output logic interrupt
);
    import sbc_spi_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [1:0] mode_code(input mode_t m);
        logic [1:0] c;
        c = REQ_NORMAL;
        if (m == MODE_STOP) begin
            c = REQ_STOP;
        end else if (m == MODE_SLEEP) begin
            c = REQ_SLEEP;
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Synchronisers and edge finding
    // ------------------------------------------------------------
    logic [1:0] sck_sync_r, sel_sync_r, sdi_sync_r;
    logic sck_d_r, sel_d_r;
    logic sck_rise, sck_fall, frame_start, frame_end;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sck_sync_r <= 2'h0;
            sel_sync_r <= 2'h3;
            sdi_sync_r <= 2'h0;
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end else begin
            sck_sync_r <= {sck_sync_r[0], sclk};
            sel_sync_r <= {sel_sync_r[0], select_low};
            sdi_sync_r <= {sdi_sync_r[0], serial_in};
            sck_d_r <= sck_sync_r[1];
            sel_d_r <= sel_sync_r[1];
        end
    end

    assign sck_rise = sck_sync_r[1] & ~sck_d_r;
    assign sck_fall = ~sck_sync_r[1] & sck_d_r;
    assign frame_start = ~sel_sync_r[1] & sel_d_r;
    assign frame_end = sel_sync_r[1] & ~sel_d_r;

    // ------------------------------------------------------------
    // Frame bookkeeping and error bit
    // ------------------------------------------------------------
    logic in_frame_r, clk_high_r, ro_seen_r, err_pend_r;
    logic [4:0] edge_cnt_r;
    logic frame_ok, frame_bad;

    assign frame_bad = ((edge_cnt_r != 5'h00) && (edge_cnt_r != FRAME_BITS))
        || clk_high_r || sck_sync_r[1] || ro_seen_r || !reset_output_n;
    assign frame_ok = frame_end && !frame_bad && (edge_cnt_r == FRAME_BITS);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_frame_r <= 1'b0;
            edge_cnt_r <= 5'h00;
            clk_high_r <= 1'b0;
            ro_seen_r <= 1'b0;
        end else if (frame_start) begin
            in_frame_r <= 1'b1;
            edge_cnt_r <= 5'h00;
            clk_high_r <= sck_sync_r[1];
            ro_seen_r <= !reset_output_n;
        end else if (in_frame_r) begin
            if (frame_end) begin
                in_frame_r <= 1'b0;
            end
            if (sck_fall && edge_cnt_r != 5'h1F) begin
                edge_cnt_r <= edge_cnt_r + 5'h01;
            end
            if (!reset_output_n) begin
                ro_seen_r <= 1'b1;
            end
        end
    end

    // Set at a frame's end, cleared once loaded at the next frame's start
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            err_pend_r <= 1'b0;
        end else if (in_frame_r && frame_end && frame_bad) begin
            err_pend_r <= 1'b1;
        end else if (frame_start) begin
            err_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shift registers
    // ------------------------------------------------------------
    logic [15:0] rx_r, tx_r;
    logic load_hi_r, fault_r;
    mode_t mode_r;
    cfg_t cfg_r;
    logic [7:0] rd_byte;
    logic [6:0] rx_addr;

    assign rx_addr = rx_r[15:9];

    always_comb begin
        rd_byte = 8'h00;
        unique case (rx_addr)
            ADDR_MODE_CTRL: rd_byte = {mode_code(mode_r), cfg_r.mode_rest};
            ADDR_WDOG: rd_byte = cfg_r.wdog;
            ADDR_BUS_CTRL: rd_byte = cfg_r.bus_ctrl;
            ADDR_WAKE_CTRL_B: rd_byte = cfg_r.wake_ctrl;
            ADDR_TIMER: rd_byte = cfg_r.timer;
            ADDR_DEV_STAT: rd_byte = {7'h00, fault_r};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_r <= 16'h0000;
        end else if (in_frame_r && sck_fall) begin
            rx_r <= {sdi_sync_r[1], rx_r[15:1]};
        end
    end

    // Address is known after the seventh bit, well before the eighth rise
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            load_hi_r <= 1'b0;
            tx_r <= 16'h0000;
        end else begin
            load_hi_r <= in_frame_r && sck_fall && (edge_cnt_r == ADDR_BITS_DONE);
            if (frame_start) begin
                tx_r <= {8'h00, 1'b0, fault_r, mode_r, err_pend_r};
            end else if (load_hi_r) begin
                tx_r[8:1] <= rd_byte;
            end else if (in_frame_r && sck_rise) begin
                tx_r <= {1'b0, tx_r[15:1]};
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out <= !reset_output_n | tx_r[0];
            serial_out_oe <= !sel_sync_r[1] && !frame_end;
        end
    end

    // ------------------------------------------------------------
    // Command interpretation
    // ------------------------------------------------------------
    cmd_t cmd;
    mode_t mode_nxt;
    cfg_t cfg_nxt;
    logic fault_set, fault_clr, trig_nxt, int_nxt;
    logic [5:0] rest_new;
    logic [1:0] req;
    logic no_wake, meas_only_pins, timer_bad;
    logic wb_hit, wb_clear;
    logic [7:0] restart_cnt_r;

    assign cmd = cmd_t'(rx_r);
    assign req = cmd.data[7:6];
    assign rest_new = cmd.data[5:0] | (cfg_r.mode_rest & (6'h01 << LS_BIT));
    assign no_wake = (cfg_r.bus_ctrl == 8'h00) && (cfg_r.wake_ctrl == 8'h00);
    assign meas_only_pins = cfg_r.wake_ctrl[WAKE_MEAS_BIT] && (cfg_r.bus_ctrl == 8'h00)
        && !cfg_r.wake_ctrl[WAKE_TIMER_BIT]
        && (cfg_r.wake_ctrl[WAKE_ONE_BIT] || cfg_r.wake_ctrl[WAKE_TWO_BIT]);
    // A zero byte means the timer is off and is accepted
    assign timer_bad = (cmd.data != 8'h00)
        && (cmd.data[7:TIMER_ON_LSB] >= cmd.data[3:0]);

    always_comb begin
        mode_nxt = mode_r;
        cfg_nxt = cfg_r;
        fault_set = 1'b0;
        fault_clr = 1'b0;
        trig_nxt = 1'b0;
        int_nxt = 1'b0;
        if (frame_ok && mode_r != MODE_RESTART && mode_r != MODE_SLEEP) begin
            if (rx_r == 16'h0000 || rx_r == 16'hFFFF) begin
                fault_set = 1'b1;
            end else if (!cmd.write) begin
                fault_set = 1'b0;
            end else if (cmd.addr[STATUS_BIT]) begin
                fault_clr = (cmd.addr == ADDR_DEV_STAT);
            end else if (cmd.addr == ADDR_WDOG) begin
                if (^cmd.data) begin
                    fault_set = 1'b1;
                end else if (mode_r == MODE_STOP && cmd.data != cfg_r.wdog) begin
                    fault_set = 1'b1;
                end else begin
                    cfg_nxt.wdog = cmd.data;
                    trig_nxt = 1'b1;
                    if (mode_r == MODE_INIT) begin
                        mode_nxt = MODE_NORMAL;
                    end
                end
            end else if (cmd.addr == ADDR_MODE_CTRL) begin
                if (req == REQ_SOFT_RESET) begin
                    mode_nxt = MODE_RESTART;
                end else if (mode_r == MODE_STOP) begin
                    if (req == REQ_SLEEP) begin
                        fault_set = 1'b1;
                        mode_nxt = MODE_RESTART;
                    end else if (req == REQ_NORMAL) begin
                        mode_nxt = MODE_NORMAL;
                    end else if (rest_new != cfg_r.mode_rest) begin
                        fault_set = 1'b1;
                    end
                end else if (mode_r == MODE_INIT && req != REQ_NORMAL) begin
                    fault_set = 1'b1;
                    mode_nxt = MODE_NORMAL;
                end else begin
                    cfg_nxt.mode_rest = rest_new;
                    mode_nxt = MODE_NORMAL;
                    if (req == REQ_STOP) begin
                        mode_nxt = MODE_STOP;
                        int_nxt = wake_status_pending;
                    end else if (req == REQ_SLEEP) begin
                        mode_nxt = MODE_SLEEP;
                        if (no_wake || meas_only_pins) begin
                            fault_set = 1'b1;
                            mode_nxt = MODE_RESTART;
                        end
                    end
                end
            end else if (cmd.addr == ADDR_BUS_CTRL || cmd.addr == ADDR_WAKE_CTRL_B
                         || cmd.addr == ADDR_TIMER) begin
                if (mode_r == MODE_STOP) begin
                    fault_set = 1'b1;
                end else if (cmd.addr == ADDR_BUS_CTRL) begin
                    cfg_nxt.bus_ctrl = cmd.data;
                end else if (cmd.addr == ADDR_WAKE_CTRL_B) begin
                    cfg_nxt.wake_ctrl = cmd.data;
                end else if (timer_bad) begin
                    fault_set = 1'b1;
                end else begin
                    cfg_nxt.timer = cmd.data;
                end
            end
        end else if (mode_r == MODE_SLEEP) begin
            if (wake_event || ((cfg_r.bus_ctrl == 8'h00)
                && (cfg_r.wake_ctrl[2:0] == (3'h1 << WAKE_TIMER_BIT))
                && (cfg_r.timer == 8'h00))) begin
                mode_nxt = MODE_RESTART;
            end
        end else if (mode_r == MODE_RESTART && restart_cnt_r == RESTART_CYCLES) begin
            mode_nxt = MODE_NORMAL;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_r <= MODE_INIT;
            cfg_r <= {6'h00, CFG_RST, CFG_RST, CFG_RST, CFG_RST};
            watchdog_trigger <= 1'b0;
            interrupt <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            cfg_r <= cfg_nxt;
            watchdog_trigger <= trig_nxt;
            interrupt <= int_nxt;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            restart_cnt_r <= 8'h00;
        end else if (mode_r != MODE_RESTART) begin
            restart_cnt_r <= 8'h00;
        end else begin
            restart_cnt_r <= restart_cnt_r + 8'h01;
        end
    end

    // Set wins over either clear path so no fault is lost
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fault_r <= 1'b0;
        end else if (fault_set) begin
            fault_r <= 1'b1;
        end else if (fault_clr || wb_clear) begin
            fault_r <= 1'b0;
        end
    end

    assign mode = mode_r;
    assign cfg = cfg_r;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign wb_hit = wb_req.cyc && wb_req.stb && !wb_ack_o;
    assign wb_clear = wb_hit && wb_req.we && (wb_req.adr == WB_CONTROL)
        && wb_req.sel[0] && wb_req.dat[CTRL_CLEAR_FAULT];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_req.we) begin
                unique case (wb_req.adr)
                    WB_STATUS: wb_dat_o <= {22'h0, mode_code(mode_r), err_pend_r,
                                            fault_r, 1'b0, mode_r};
                    WB_CONFIG: wb_dat_o <= {cfg_r.bus_ctrl, cfg_r.wake_ctrl,
                                            cfg_r.timer, 2'b00, cfg_r.mode_rest};
                    WB_WDOG: wb_dat_o <= {24'h0, cfg_r.wdog};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### test/sbc_spi_monitor.sv
// Concurrent checks on the serial command port, bound to sbc_spi_checker.
// Assumes one clock domain and link controls held steady between frames.
`timescale 1ns/1ns
`default_nettype none
module sbc_spi_monitor (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic select_low,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic reset_output_n,
    input wire logic wake_status_pending,
    input wire sbc_spi_pkg::mode_t mode,
    input wire sbc_spi_pkg::cfg_t cfg,
    input wire logic interrupt
);
    import sbc_spi_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    logic sclk_q_r;
    logic [3:0] since_rise_r;
    // Link clock is asynchronous, so the bound allows for synchroniser lag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_q_r <= 1'b0;
            since_rise_r <= 4'hF;
        end else begin
            sclk_q_r <= sclk;
            if (sclk && !sclk_q_r) since_rise_r <= 4'h0;
            else if (since_rise_r != 4'hF) since_rise_r <= since_rise_r + 4'h1;
        end
    end
    sequence s_open;
        $fell(select_low) ##1 !select_low [*6];
    endsequence
    sequence s_close;
        $rose(select_low) ##1 select_low [*5];
    endsequence
    property p_open_drive;
        s_open |-> serial_out_oe;
    endproperty
    a_open_drive: assert property (p_open_drive)
        else $error("output not driven in frame");
    property p_close_release;
        s_close |-> !serial_out_oe;
    endproperty
    a_close_release: assert property (p_close_release)
        else $error("output still driven after frame");
    property p_shift_on_rise;
        (!select_low && !$past(select_low, 6) && $changed(serial_out) && reset_output_n
            && $past(reset_output_n)) |-> since_rise_r < 4'h8;
    endproperty
    a_shift_on_rise: assert property (p_shift_on_rise)
        else $error("output changed without link clock rise");
    property p_ro_high;
        (!reset_output_n) [*2] |-> serial_out;
    endproperty
    a_ro_high: assert property (p_ro_high)
        else $error("output not high while reset output low");
    property p_int_stop;
        interrupt |-> wake_status_pending ##[0:1] (mode == MODE_STOP);
    endproperty
    a_int_stop: assert property (p_int_stop)
        else $error("interrupt without stop entry");
    property p_no_stop_sleep;
        ($past(mode) == MODE_STOP) |-> (mode != MODE_SLEEP);
    endproperty
    a_no_stop_sleep: assert property (p_no_stop_sleep)
        else $error("stop went straight to sleep");
    property p_init_exit;
        ($past(mode) == MODE_INIT) |-> (mode inside {MODE_INIT, MODE_NORMAL});
    endproperty
    a_init_exit: assert property (p_init_exit)
        else $error("init left to a low power mode");
    property p_stop_hold;
        (mode == MODE_STOP && $past(mode) == MODE_STOP) |-> $stable(cfg);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("configuration changed in stop");
    property p_stop_normal;
        ($past(mode) == MODE_STOP && mode == MODE_NORMAL) |-> $stable(cfg);
    endproperty
    a_stop_normal: assert property (p_stop_normal)
        else $error("stop exit changed other bits");
    property p_ls_keep;
        $past(cfg.mode_rest[LS_BIT]) |-> cfg.mode_rest[LS_BIT];
    endproperty
    a_ls_keep: assert property (p_ls_keep)
        else $error("load sharing was cleared");
endmodule
bind sbc_spi_checker sbc_spi_monitor mon_u (
    .clock(clock), .resetn(resetn), .sclk(sclk), .select_low(select_low),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .reset_output_n(reset_output_n), .wake_status_pending(wake_status_pending),
    .mode(mode), .cfg(cfg), .interrupt(interrupt)
);
`default_nettype wire

// ### test/spi_ctrl_model.sv
// Controller side of the serial link: 16-bit frames, LSB first.
// Assumes the device samples on link clock fall and shifts after its rise.
`timescale 1ns/1ns
`default_nettype none
module spi_ctrl_model (
    input wire logic clock,
    output logic sclk,
    output logic select_low,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    logic miso;
    assign miso = serial_out_oe ? serial_out : 1'bx;
    initial begin
        sclk = 1'b0;
        select_low = 1'b1;
        serial_in = 1'b0;
    end
    // Four clocks a half period give the 320 ns link period
    task automatic frame(input logic [15:0] w, input int nclk, input bit hi,
                         output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clock);
        select_low <= 1'b0;
        sclk <= hi;
        repeat (4) @(posedge clock);
        sclk <= 1'b0;
        repeat (8) @(posedge clock);
        for (int i = 0; i < nclk; i++) begin
            rx[i] = miso;
            serial_in <= w[i];
            sclk <= 1'b1;
            repeat (4) @(posedge clock);
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
        end
        if (nclk == 0) rx[0] = miso;
        // Released input flips so a stale level is never mistaken for data
        serial_in <= ~serial_in;
        select_low <= 1'b1;
        sclk <= hi;
        repeat (4) @(posedge clock);
        sclk <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ### test/sbc_spi_checker_tb.sv
// Self-checking bench for the SBC serial command port.
// Assumes the link model drives frames and Wishbone tasks read results.
`timescale 1ns/1ns
`default_nettype none
module sbc_spi_checker_tb;
    import sbc_spi_pkg::*;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    logic clock, resetn, sclk, select_low, serial_in, serial_out, serial_out_oe;
    logic reset_output_n, wake_status_pending, wake_event, wb_ack_o;
    logic watchdog_trigger, interrupt;
    wb_req_t wb_req;
    logic [31:0] wb_dat_o, q;
    mode_t mode;
    cfg_t cfg;
    logic [15:0] rx;
    logic [7:0] wk [3] = '{8'h00, 8'h09, 8'h04};
    logic wf [3] = '{1'b1, 1'b1, 1'b0};
    int n_fail = 0, comparisons = 0, cycles = 0, n_trig = 0, n_int = 0;
    sbc_spi_checker dut_u (.clock(clock), .resetn(resetn), .sclk(sclk),
        .select_low(select_low), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .reset_output_n(reset_output_n),
        .wake_status_pending(wake_status_pending), .wake_event(wake_event),
        .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode(mode),
        .cfg(cfg), .watchdog_trigger(watchdog_trigger), .interrupt(interrupt));
    spi_ctrl_model ctl_u (.clock(clock), .sclk(sclk), .select_low(select_low),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (watchdog_trigger === 1'b1) n_trig++;
        if (interrupt === 1'b1) n_int++;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for ack with no assumed latency
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_req <= '0;
    endtask
    task automatic status(input logic fault, input mode_t m);
        wb(1'b0, WB_STATUS, 32'h0);
        check({26'h0, q[6], q[4:0]}, {26'h0, fault, m});
    endtask
    task automatic clr();
        wb(1'b1, WB_CONTROL, 32'h1);
    endtask
    task automatic spi(input logic [15:0] w);
        ctl_u.frame(w, 16, 1'b0, rx);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        reset_output_n = 1'b1;
        wake_status_pending = 1'b0;
        wake_event = 1'b0;
        wb_req = '0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        status(1'b0, MODE_INIT);
        spi(16'h8081);
        status(1'b1, MODE_NORMAL);
        clr();
        status(1'b0, MODE_NORMAL);
        spi(16'h0783);
        check(32'(cfg.wdog), 32'h0);
        check(n_trig, 0);
        spi(16'h0383);
        check(32'(cfg.wdog), 32'h03);
        check(n_trig, 1);
        status(1'b1, MODE_NORMAL);
        clr();
        spi(16'hFFFF);
        status(1'b1, MODE_NORMAL);
        clr();
        spi(16'h0000);
        status(1'b1, MODE_NORMAL);
        spi(16'h02C3);
        spi(16'h559A);
        status(1'b0, MODE_NORMAL);
        spi(16'h3386);
        check(32'(cfg.timer), 32'h0);
        status(1'b1, MODE_NORMAL);
        clr();
        spi(16'h2386);
        check(32'(cfg.timer), 32'h23);
        ctl_u.frame(16'h0583, 8, 1'b0, rx);
        check(32'(cfg.wdog), 32'h03);
        ctl_u.frame(16'h0, 0, 1'b0, rx);
        check(32'(rx[0]), 32'h1);
        spi(16'h0043);
        check(32'(rx[0]), 32'h0);
        ctl_u.frame(16'h0043, 16, 1'b1, rx);
        ctl_u.frame(16'h0, 0, 1'b0, rx);
        check(32'(rx[0]), 32'h1);
        reset_output_n <= 1'b0;
        repeat (4) @(posedge clock);
        check(32'(serial_out), 32'h1);
        spi(16'h0043);
        check(32'(rx), 32'hFFFF);
        reset_output_n <= 1'b1;
        ctl_u.frame(16'h0, 0, 1'b0, rx);
        check(32'(rx[0]), 32'h1);
        wake_status_pending <= 1'b1;
        spi(16'h8081);
        status(1'b0, MODE_STOP);
        check(n_int, 1);
        wake_status_pending <= 1'b0;
        spi(16'h5584);
        check(32'(cfg.bus_ctrl), 32'h0);
        status(1'b1, MODE_STOP);
        clr();
        spi(16'h1081);
        status(1'b0, MODE_NORMAL);
        check(32'(cfg.mode_rest[LS_BIT]), 32'h0);
        spi(16'h1081);
        spi(16'h0081);
        check(32'(cfg.mode_rest[LS_BIT]), 32'h1);
        spi(16'h8081);
        spi(16'hC081);
        status(1'b0, MODE_RESTART);
        repeat (130) @(posedge clock);
        spi(16'h8081);
        spi(16'h4081);
        status(1'b1, MODE_RESTART);
        repeat (130) @(posedge clock);
        status(1'b1, MODE_NORMAL);
        clr();
        spi(16'h0086);
        for (int i = 0; i < 3; i++) begin
            spi({wk[i], 8'h85});
            spi(16'h4081);
            status(wf[i], MODE_RESTART);
            repeat (130) @(posedge clock);
            clr();
        end
        summarize();
    end
endmodule
`default_nettype wire
